// *** rtl/acseq_top.v ***
// comparator sequencing logic: sampling, single-shot control, flags, events, register slave
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "acseq_regs.vh"

module acseq_top #(
  parameter integer STARTUP_CYC = `ACSEQ_STARTUP_CYC,
  parameter integer CNT_W       = 12
) (
  input  wire        sys_clk_i,
  input  wire        arst_n_i,
  input  wire [5:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [3:0]  avs_byteenable_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire [1:0]  cmp_out_i,
  output reg  [1:0]  cmp_enable_o,
  input  wire [1:0]  ev_in_i,
  output reg  [2:0]  ev_out_o,
  input  wire        standby_i,
  output reg         irq_o,
  output reg         clk_req_o,
  output reg         wake_o
);

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam [3:0] S_OFF     = 4'h1;
  localparam [3:0] S_STARTUP = 4'h2;
  localparam [3:0] S_RUN     = 4'h4;
  localparam [3:0] S_IDLE    = 4'h8;
  localparam [31:0]      STARTUP_M1   = STARTUP_CYC - 1;
  localparam [CNT_W-1:0] STARTUP_LAST = STARTUP_M1[CNT_W-1:0];

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg  [1:0]       ctrl;
  reg  [3:0]       compctrl [0:1];
  reg  [4:0]       evctrl;
  reg  [2:0]       winctrl;
  reg  [2:0]       irq_enable;
  reg  [2:0]       irq_flag_reg;
  reg  [1:0]       cmp_meta;
  reg  [1:0]       cmp_sync;
  reg  [3:0]       st [0:1];
  reg  [CNT_W-1:0] cnt [0:1];
  reg  [1:0]       result_status;
  reg  [1:0]       prev_result;
  reg  [1:0]       result_vld;
  reg  [1:0]       ready_flag;
  reg  [1:0]       wstate;
  reg              stc_armed;
  reg  [31:0]      rd_mux;
  reg  [1:0]       active;
  reg  [1:0]       single;
  reg  [1:0]       trig;
  reg  [2:0]       irq_hit;
  reg  [1:0]       next_wstate;
  wire             req;
  wire             done_wr;
  wire             stc_sel;
  wire             stc_fire;
  wire             all_ready;
  wire [1:0]       ev_hit;
  wire [1:0]       ev_trig;
  wire             win_en;
  wire [1:0]       sw_start;
  wire [1:0]       toggled;
  integer          k;
  integer          n;
  integer          m;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // request taken when the slave drops waitrequest; writes land at that edge
  assign req      = avs_read_i | avs_write_i;
  assign done_wr  = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign stc_sel  = avs_read_i & (avs_address_i == `ACSEQ_TRIGSTAT_OFS);
  // first cycle of a triggered-status read fires the starts
  assign stc_fire = stc_sel & avs_waitrequest_o & ~stc_armed;
  // comparators that are not active count as ready
  assign all_ready = &(ready_flag | ~active);
  assign sw_start = (done_wr && avs_address_i == `ACSEQ_START_OFS) ?
                    avs_writedata_i[1:0] : 2'h0;
  assign win_en   = winctrl[`ACSEQ_WIN_EN_BIT];

  // input events gated by their enables; window pairs share the trigger
  assign ev_hit  = ev_in_i & evctrl[`ACSEQ_EV_IN_LSB +: 2];
  assign ev_trig = win_en ? {2{|ev_hit}} : ev_hit;

  // per-comparator activity and trigger collection
  always @* begin
    for (n = 0; n < 2; n = n + 1) begin
      single[n] = compctrl[n][`ACSEQ_CC_SINGLE_BIT];
      // standby without keep-running powers the comparator down
      active[n] = ctrl[`ACSEQ_CTRL_ENABLE_BIT] &
                  (~standby_i | compctrl[n][`ACSEQ_CC_STDBY_BIT]);
      // busy comparators are not in idle, so no further start is taken
      trig[n]   = single[n] & (sw_start[n] | stc_fire | ev_trig[n]);
    end
  end

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  // analog outputs are asynchronous to the logic clock
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_meta <= 2'h0;
      cmp_sync <= 2'h0;
    end else begin
      cmp_meta <= cmp_out_i;
      cmp_sync <= cmp_meta;
    end
  end

  // ---------------------------------------------------------------
  // comparator sequencers
  // ---------------------------------------------------------------
  // startup count, continuous sampling or one comparison per trigger
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (k = 0; k < 2; k = k + 1) begin
        st[k]  <= S_OFF;
        cnt[k] <= {CNT_W{1'b0}};
      end
      result_status <= 2'h0;
      prev_result   <= 2'h0;
      result_vld    <= 2'h0;
      ready_flag    <= 2'h0;
      cmp_enable_o  <= 2'h0;
    end else begin
      result_vld <= 2'h0;
      for (k = 0; k < 2; k = k + 1) begin
        case (st[k])
          S_OFF: begin
            ready_flag[k] <= 1'b0;
            if (active[k]) begin
              cnt[k] <= STARTUP_LAST;
              if (single[k]) begin
                st[k] <= S_IDLE;
              end else begin
                st[k]           <= S_STARTUP;
                cmp_enable_o[k] <= 1'b1;
              end
            end
          end
          S_STARTUP: begin
            if (!active[k]) begin
              st[k]           <= S_OFF;
              cmp_enable_o[k] <= 1'b0;
            end else if (cnt[k] == {CNT_W{1'b0}}) begin
              // sample only once the startup count has run out
              prev_result[k]   <= result_status[k];
              result_status[k] <= cmp_sync[k];
              result_vld[k]    <= 1'b1;
              ready_flag[k]    <= 1'b1;
              if (single[k]) begin
                st[k]           <= S_IDLE;
                cmp_enable_o[k] <= 1'b0;
              end else begin
                st[k] <= S_RUN;
              end
            end else begin
              cnt[k] <= cnt[k] - 1'b1;
            end
          end
          S_RUN: begin
            if (!active[k] || single[k]) begin
              st[k]           <= active[k] ? S_IDLE : S_OFF;
              cmp_enable_o[k] <= 1'b0;
              ready_flag[k]   <= 1'b0;
            end else begin
              // one sample per logic clock cycle
              prev_result[k]   <= result_status[k];
              result_status[k] <= cmp_sync[k];
              result_vld[k]    <= 1'b1;
            end
          end
          S_IDLE: begin
            if (!active[k]) begin
              st[k] <= S_OFF;
            end else if (!single[k] || trig[k]) begin
              // start clears ready; comparator powered for startup
              st[k]           <= S_STARTUP;
              cnt[k]          <= STARTUP_LAST;
              cmp_enable_o[k] <= 1'b1;
              ready_flag[k]   <= 1'b0;
            end
          end
          default: begin
            st[k]           <= S_OFF;
            cmp_enable_o[k] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // window state and interrupt conditions
  // ---------------------------------------------------------------
  // first comparator holds the lower bound, second the upper bound
  always @* begin
    if (result_status[1]) begin
      next_wstate = `ACSEQ_WST_ABOVE;
    end else if (result_status[0]) begin
      next_wstate = `ACSEQ_WST_INSIDE;
    end else begin
      next_wstate = `ACSEQ_WST_BELOW;
    end
  end

  // edge found by comparing the new result with the one before it
  always @* begin
    irq_hit = 3'h0;
    for (m = 0; m < 2; m = m + 1) begin
      if (result_vld[m]) begin
        case (compctrl[m][`ACSEQ_CC_ISEL_LSB +: 2])
          `ACSEQ_ISEL_TOGGLE: irq_hit[m] = result_status[m] ^ prev_result[m];
          `ACSEQ_ISEL_RISE:   irq_hit[m] = result_status[m] & ~prev_result[m];
          `ACSEQ_ISEL_FALL:   irq_hit[m] = ~result_status[m] & prev_result[m];
          default:            irq_hit[m] = 1'b1;
        endcase
      end
    end
    if (win_en && (|result_vld) && next_wstate != wstate) begin
      case (winctrl[`ACSEQ_WIN_ISEL_LSB +: 2])
        `ACSEQ_WSEL_ABOVE:  irq_hit[2] = (next_wstate == `ACSEQ_WST_ABOVE);
        `ACSEQ_WSEL_INSIDE: irq_hit[2] = (next_wstate == `ACSEQ_WST_INSIDE);
        `ACSEQ_WSEL_BELOW:  irq_hit[2] = (next_wstate == `ACSEQ_WST_BELOW);
        default:            irq_hit[2] = (wstate == `ACSEQ_WST_INSIDE);
      endcase
    end
  end

  // window state tracks comparator results while window mode is on
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wstate <= `ACSEQ_WST_BELOW;
    end else if (win_en && (|result_vld)) begin
      wstate <= next_wstate;
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags, enables and request line
  // ---------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_flag_reg <= 3'h0;
      irq_enable   <= `ACSEQ_INTEN_RST;
      irq_o        <= 1'b0;
    end else begin
      if (done_wr && avs_address_i == `ACSEQ_IRQ_FLAG_REG_OFS) begin
        irq_flag_reg <= (irq_flag_reg & ~avs_writedata_i[2:0]) | irq_hit;
      end else begin
        irq_flag_reg <= irq_flag_reg | irq_hit;
      end
      if (done_wr && avs_address_i == `ACSEQ_IRQ_ENABLE_SET_OFS) begin
        irq_enable <= irq_enable | avs_writedata_i[2:0];
      end else if (done_wr && avs_address_i == `ACSEQ_IRQ_ENABLE_CLEAR_OFS) begin
        irq_enable <= irq_enable & ~avs_writedata_i[2:0];
      end
      // one combined line, active while any enabled flag stands
      irq_o <= |(irq_flag_reg & irq_enable);
    end
  end

  // ---------------------------------------------------------------
  // output events and sleep clock request
  // ---------------------------------------------------------------
  assign toggled = result_vld & (result_status ^ prev_result);

  // events copy status; clock request is held for one cycle per toggle
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ev_out_o  <= 3'h0;
      clk_req_o <= 1'b0;
      wake_o    <= 1'b0;
    end else begin
      ev_out_o <= {win_en && next_wstate == `ACSEQ_WST_INSIDE, result_status} &
                  evctrl[`ACSEQ_EV_OUT_LSB +: 3];
      // toggle during standby asks for the logic clock
      clk_req_o <= standby_i & (|toggled);
      // without wake configured the request falls after one cycle
      if (!standby_i) begin
        wake_o <= 1'b0;
      end else if (clk_req_o && ctrl[`ACSEQ_CTRL_WAKE_BIT]) begin
        wake_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read multiplexer
  // ---------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `ACSEQ_CTRL_OFS:      rd_mux[1:0] = ctrl;
      `ACSEQ_EVCTRL_OFS:    rd_mux[4:0] = evctrl;
      `ACSEQ_COMPCTRL0_OFS: rd_mux[3:0] = compctrl[0];
      `ACSEQ_COMPCTRL1_OFS: rd_mux[3:0] = compctrl[1];
      `ACSEQ_WINCTRL_OFS:   rd_mux[2:0] = winctrl;
      `ACSEQ_IRQ_ENABLE_CLEAR_OFS:  rd_mux[2:0] = irq_enable;
      `ACSEQ_IRQ_ENABLE_SET_OFS:  rd_mux[2:0] = irq_enable;
      `ACSEQ_IRQ_FLAG_REG_OFS:   rd_mux[2:0] = irq_flag_reg;
      `ACSEQ_READY_OFS:     rd_mux[1:0] = ready_flag;
      `ACSEQ_RESULT_OFS, `ACSEQ_TRIGSTAT_OFS: begin
        rd_mux[1:0] = result_status;
        rd_mux[`ACSEQ_RES_WSTATE_LSB +: 2] = wstate;
      end
      default:              rd_mux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus slave and configuration registers
  // ---------------------------------------------------------------
  // answers one cycle after a request, triggered-status reads wait for ready
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      stc_armed         <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
      if (stc_fire) begin
        stc_armed <= 1'b1;
      end else if (req && avs_waitrequest_o && (!stc_sel || (stc_armed && all_ready))) begin
        // stall holds until every active comparator reports ready
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= rd_mux;
        stc_armed         <= 1'b0;
      end
    end
  end

  // configuration writes land at the completing edge
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl        <= `ACSEQ_CTRL_RST;
      compctrl[0] <= `ACSEQ_CC_RST;
      compctrl[1] <= `ACSEQ_CC_RST;
      evctrl      <= `ACSEQ_EVCTRL_RST;
      winctrl     <= `ACSEQ_WINCTRL_RST;
    end else if (done_wr) begin
      case (avs_address_i)
        `ACSEQ_CTRL_OFS:      ctrl        <= avs_writedata_i[1:0];
        `ACSEQ_COMPCTRL0_OFS: compctrl[0] <= avs_writedata_i[3:0];
        `ACSEQ_COMPCTRL1_OFS: compctrl[1] <= avs_writedata_i[3:0];
        `ACSEQ_EVCTRL_OFS:    evctrl      <= avs_writedata_i[4:0];
        `ACSEQ_WINCTRL_OFS:   winctrl     <= avs_writedata_i[2:0];
        default:              ctrl        <= ctrl;
      endcase
    end
  end

endmodule

// *** rtl/acseq_regs.vh ***
// register offsets, field positions, reset values and timing counts of the comparator sequencer
`ifndef ACSEQ_REGS_VH
`define ACSEQ_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ACSEQ_CTRL_OFS      6'h00
`define ACSEQ_START_OFS     6'h04
`define ACSEQ_EVCTRL_OFS    6'h08
`define ACSEQ_COMPCTRL0_OFS 6'h0c
`define ACSEQ_COMPCTRL1_OFS 6'h10
`define ACSEQ_WINCTRL_OFS   6'h14
`define ACSEQ_IRQ_ENABLE_CLEAR_OFS  6'h18
`define ACSEQ_IRQ_ENABLE_SET_OFS  6'h1c
`define ACSEQ_IRQ_FLAG_REG_OFS   6'h20
`define ACSEQ_RESULT_OFS    6'h24
`define ACSEQ_READY_OFS     6'h28
`define ACSEQ_TRIGSTAT_OFS  6'h2c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACSEQ_CTRL_ENABLE_BIT  0
`define ACSEQ_CTRL_WAKE_BIT    1
`define ACSEQ_CC_SINGLE_BIT    0
`define ACSEQ_CC_ISEL_LSB      1
`define ACSEQ_CC_STDBY_BIT     3
`define ACSEQ_EV_OUT_LSB       0
`define ACSEQ_EV_IN_LSB        4
`define ACSEQ_WIN_EN_BIT       0
`define ACSEQ_WIN_ISEL_LSB     1
`define ACSEQ_RES_WSTATE_LSB   4

// ---------------------------------------------------------------
// reset values and encodings
// ---------------------------------------------------------------
`define ACSEQ_CTRL_RST      2'h0
`define ACSEQ_CC_RST        4'h0
`define ACSEQ_EVCTRL_RST    5'h00
`define ACSEQ_WINCTRL_RST   3'h0
`define ACSEQ_INTEN_RST     3'h0
`define ACSEQ_ISEL_TOGGLE   2'h0
`define ACSEQ_ISEL_RISE     2'h1
`define ACSEQ_ISEL_FALL     2'h2
`define ACSEQ_ISEL_EOC      2'h3
`define ACSEQ_WSEL_ABOVE    2'h0
`define ACSEQ_WSEL_INSIDE   2'h1
`define ACSEQ_WSEL_BELOW    2'h2
`define ACSEQ_WSEL_OUTSIDE  2'h3
`define ACSEQ_WST_ABOVE     2'h0
`define ACSEQ_WST_INSIDE    2'h1
`define ACSEQ_WST_BELOW     2'h2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ACSEQ_CLK_MHZ       50
`define ACSEQ_STARTUP_NS    2000
`define ACSEQ_STARTUP_CYC   ((`ACSEQ_STARTUP_NS * `ACSEQ_CLK_MHZ + 999) / 1000)

`endif

// *** test/acseq_evnet_model.sv ***
// event network and interrupt controller stand-in for the comparator sequencer
`timescale 1ns/1ps
module acseq_evnet_model (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire [1:0] fire_i,
  input  wire       irq_i,
  output reg  [1:0] ev_o,
  output reg  [7:0] irq_cnt_o
);
  reg irq_q;
  // one-cycle event pulses out, rising interrupt requests counted
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_o <= 2'h0;
      irq_q <= 1'b0;
      irq_cnt_o <= 8'h00;
    end else begin
      ev_o <= fire_i;
      irq_q <= irq_i;
      if (irq_i && !irq_q) irq_cnt_o <= irq_cnt_o + 8'h01;
    end
  end
endmodule

// *** test/acseq_chk.sv ***
// port assertions for the comparator sequencer
`timescale 1ns/1ps
`include "acseq_regs.vh"
module acseq_chk #(
  parameter integer STARTUP_CYC = 4
) (
  input wire       sys_clk_i,
  input wire       arst_n_i,
  input wire [5:0] avs_address_i,
  input wire       avs_read_i,
  input wire       avs_write_i,
  input wire       avs_waitrequest_o,
  input wire [1:0] cmp_enable_o,
  input wire [2:0] ev_out_o,
  input wire       standby_i,
  input wire       irq_o,
  input wire       clk_req_o,
  input wire       wake_o
);
  reg [7:0] on_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // cycles comparator 0 has stayed powered
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) on_cnt <= 8'h00;
    else if (!cmp_enable_o[0]) on_cnt <= 8'h00;
    else if (on_cnt != 8'hff) on_cnt <= on_cnt + 8'h01;
  end
  property p_ans; !avs_waitrequest_o |-> (avs_read_i || avs_write_i) ##1 avs_waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("answer without request");
  property p_trig; $rose(avs_read_i) && avs_address_i == `ACSEQ_TRIGSTAT_OFS |-> avs_waitrequest_o[*2]; endproperty
  a_trig: assert property (p_trig) else $error("triggered read not stalled");
  property p_start; $fell(cmp_enable_o[0]) && $past(arst_n_i) |-> on_cnt >= STARTUP_CYC; endproperty
  a_start: assert property (p_start) else $error("comparison before startup");
  property p_req; clk_req_o |-> $past(standby_i) ##1 !clk_req_o; endproperty
  a_req: assert property (p_req) else $error("clock request outside standby");
  property p_wake; $rose(wake_o) |-> $past(clk_req_o); endproperty
  a_wake: assert property (p_wake) else $error("wake without clock request");
  property p_wake_off; !standby_i |=> !wake_o; endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake held after standby");
  property p_irq; $fell(irq_o) && $past(arst_n_i) |-> $past(avs_write_i, 2); endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped unasked");
  property p_win; ev_out_o[2] |-> !ev_out_o[1]; endproperty
  a_win: assert property (p_win) else $error("inside event with upper high");
endmodule
bind acseq_top acseq_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .cmp_enable_o(cmp_enable_o), .ev_out_o(ev_out_o), .standby_i(standby_i), .irq_o(irq_o),
  .clk_req_o(clk_req_o), .wake_o(wake_o));

// *** test/comparator_sequencing_logic_bench.sv ***
// self-checking bench for the comparator sequencer
`timescale 1ns/1ps
`include "acseq_regs.vh"
module comparator_sequencing_logic_bench;
  localparam integer ST = 4;
  localparam [29:0] SHOT = {6'h07, 6'h04, 6'h15, 6'h0e, 6'h1f};
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [5:0]  adr = 6'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg  [1:0]  cmp = 2'h0;
  reg  [1:0]  fire = 2'h0;
  reg         stby = 1'b0;
  wire [31:0] rdata;
  wire        wreq;
  wire [1:0]  cen;
  wire [1:0]  ev_in;
  wire [2:0]  ev_out;
  wire        irq;
  wire        clk_req;
  wire        wake;
  wire [7:0]  irq_cnt;
  integer     fails = 0;
  integer     checked = 0;
  integer     cyc = 0;
  integer     wn = 0;
  integer     en_hi = 0;
  logic [31:0] q;

  acseq_top #(.STARTUP_CYC(ST)) dut (.sys_clk_i(clk), .arst_n_i(rst_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf),
    .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .cmp_out_i(cmp), .cmp_enable_o(cen), .ev_in_i(ev_in), .ev_out_o(ev_out),
    .standby_i(stby), .irq_o(irq), .clk_req_o(clk_req), .wake_o(wake));
  acseq_evnet_model u_net (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .irq_i(irq),
    .ev_o(ev_in), .irq_cnt_o(irq_cnt));

  // ------------------------------------------------------------
  // clock, timeout and powered-cycle count
  // ------------------------------------------------------------
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cen[0] === 1'b1) en_hi <= en_hi + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test;
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    begin
      wn = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wreq !== 1'b0 && wn < 300) begin
        wn = wn + 1;
        @(posedge clk);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (wn == 300) begin
        fails = fails + 1;
        stop_test;
      end
    end
  endtask
  task rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, q & m);
    end
  endtask
  task shot_ev(input logic [1:0] f, input logic [1:0] e, input string nm);
    begin
      @(posedge clk);
      fire <= f;
      @(posedge clk);
      fire <= 2'h0;
      tick(3);
      chk(nm, e, cen);
      tick(10);
    end
  endtask
  task wait_req;
    begin
      wn = 0;
      while (clk_req !== 1'b1 && wn < 10) begin
        @(posedge clk);
        wn = wn + 1;
      end
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    begin
      rdchk(`ACSEQ_CTRL_OFS, 32'hffffffff, 32'h0, "ctrl reset");
      bus(1'b1, 6'h3c, 32'hff);
      rdchk(6'h3c, 32'hffffffff, 32'h0, "unmapped");
      rdchk(`ACSEQ_IRQ_ENABLE_SET_OFS, 32'hffffffff, 32'h0, "enable reset");
      $display("test registers done");
    end
  endtask
  task t_single;
    integer i;
    logic [5:0] e;
    begin
      bus(1'b1, `ACSEQ_COMPCTRL0_OFS, 32'h7);
      bus(1'b1, `ACSEQ_IRQ_ENABLE_SET_OFS, 32'h1);
      bus(1'b1, `ACSEQ_CTRL_OFS, 32'h1);
      for (i = 0; i < 5; i = i + 1) begin
        e = SHOT[6*i +: 6];
        cmp <= {1'b0, e[1]};
        bus(1'b1, `ACSEQ_IRQ_FLAG_REG_OFS, 32'h7);
        bus(1'b1, `ACSEQ_COMPCTRL0_OFS, {28'h0, e[5:2]});
        bus(1'b1, `ACSEQ_START_OFS, 32'h1);
        if (i == 0) rdchk(`ACSEQ_READY_OFS, 32'h1, 32'h0, "ready after start");
        tick(12);
        rdchk(`ACSEQ_IRQ_FLAG_REG_OFS, 32'h1, {31'h0, e[0]}, "compare flag");
      end
      chk("idle after shot", 0, cen[0]);
      rdchk(`ACSEQ_READY_OFS, 32'h1, 32'h1, "ready done");
      rdchk(`ACSEQ_RESULT_OFS, 32'h1, 32'h1, "result");
      chk("irq", 1, irq);
      chk("irq count", 3, irq_cnt);
      bus(1'b1, `ACSEQ_IRQ_ENABLE_CLEAR_OFS, 32'h1);
      tick(2);
      chk("irq masked", 0, irq);
      bus(1'b1, `ACSEQ_IRQ_ENABLE_SET_OFS, 32'h1);
      tick(2);
      chk("irq unmasked", 1, irq);
      bus(1'b1, `ACSEQ_IRQ_FLAG_REG_OFS, 32'h1);
      tick(2);
      chk("irq cleared", 0, irq);
      $display("test single shot done");
    end
  endtask
  task t_trig;
    integer en0;
    begin
      bus(1'b1, `ACSEQ_COMPCTRL1_OFS, 32'h1);
      cmp <= 2'h2;
      tick(4);
      rdchk(`ACSEQ_TRIGSTAT_OFS, 32'h3, 32'h2, "triggered result");
      chk("triggered stall", 1, wn >= ST);
      rdchk(`ACSEQ_READY_OFS, 32'h3, 32'h3, "all ready");
      en0 = en_hi;
      bus(1'b1, `ACSEQ_START_OFS, 32'h1);
      rdchk(`ACSEQ_TRIGSTAT_OFS, 32'h3, 32'h2, "busy triggered");
      tick(2);
      chk("no restart", 1, en_hi - en0 <= ST + 1);
      $display("test triggered read done");
    end
  endtask
  task t_event;
    begin
      bus(1'b1, `ACSEQ_EVCTRL_OFS, 32'h10);
      shot_ev(2'h2, 2'h0, "foreign event");
      shot_ev(2'h1, 2'h1, "own event");
      rdchk(`ACSEQ_READY_OFS, 32'h1, 32'h1, "event ready");
      bus(1'b1, `ACSEQ_WINCTRL_OFS, 32'h1);
      shot_ev(2'h1, 2'h3, "window event");
      rdchk(`ACSEQ_IRQ_FLAG_REG_OFS, 32'h4, 32'h4, "window flag");
      bus(1'b1, `ACSEQ_EVCTRL_OFS, 32'h0);
      shot_ev(2'h1, 2'h0, "events off");
      $display("test events in done");
    end
  endtask
  task t_evout;
    begin
      bus(1'b1, `ACSEQ_COMPCTRL0_OFS, 32'h0);
      bus(1'b1, `ACSEQ_COMPCTRL1_OFS, 32'h0);
      bus(1'b1, `ACSEQ_EVCTRL_OFS, 32'h7);
      cmp <= 2'h1;
      tick(20);
      chk("events out", 5, ev_out);
      bus(1'b1, `ACSEQ_EVCTRL_OFS, 32'h0);
      tick(3);
      chk("events gated", 0, ev_out);
      bus(1'b1, `ACSEQ_IRQ_FLAG_REG_OFS, 32'h7);
      cmp <= 2'h0;
      tick(10);
      rdchk(`ACSEQ_IRQ_FLAG_REG_OFS, 32'h1, 32'h1, "running toggle");
      $display("test events out done");
    end
  endtask
  task t_sleep;
    begin
      bus(1'b1, `ACSEQ_COMPCTRL0_OFS, 32'h8);
      stby <= 1'b1;
      tick(6);
      chk("standby power", 1, cen);
      cmp <= 2'h1;
      wait_req;
      chk("sleep toggle", 1, clk_req);
      tick(2);
      chk("no wake", 0, wake);
      bus(1'b1, `ACSEQ_CTRL_OFS, 32'h3);
      cmp <= 2'h0;
      wait_req;
      tick(2);
      chk("wake", 1, wake);
      stby <= 1'b0;
      tick(2);
      chk("wake dropped", 0, wake);
      $display("test sleep done");
    end
  endtask

  // reset for ten cycles, then run every scenario
  initial begin
    tick(10);
    chk("wait in reset", 1, wreq);
    chk("irq in reset", 0, irq);
    rst_n <= 1'b1;
    t_regs;
    t_single;
    t_trig;
    t_event;
    t_evout;
    t_sleep;
    stop_test;
  end
endmodule
